// *** src/pattern_readout_pkg.sv ***
/*
 * Shared constants and types for the pattern-register readout formatter.
 * Assumes a 16-lane data path, 8-UI bursts and four 8-bit patterns.
 */
package pattern_readout_pkg;

    // Readout layout codes of mode_register_three
    localparam logic [1:0] LAYOUT_SERIAL    = 2'h0;
    localparam logic [1:0] LAYOUT_PARALLEL  = 2'h1;
    localparam logic [1:0] LAYOUT_STAGGERED = 2'h2;
    localparam logic [1:0] LAYOUT_RESERVED  = 2'h3;

    // Device width codes
    localparam logic [1:0] WIDTH_X4  = 2'h0;
    localparam logic [1:0] WIDTH_X8  = 2'h1;
    localparam logic [1:0] WIDTH_X16 = 2'h2;

    // Lane enable masks per width
    localparam logic [15:0] LANE_MASK_X4  = 16'h000f;
    localparam logic [15:0] LANE_MASK_X8  = 16'h00ff;
    localparam logic [15:0] LANE_MASK_X16 = 16'hffff;

    localparam int LANES      = 16;
    localparam int BURST_UI   = 8;
    localparam int PAT_BITS   = 8;
    localparam int PAT_LOCS   = 4;
    localparam int LAT_W      = 6;
    localparam int FIFO_DEPTH = 16;

    // Shortest latency the link side will count
    localparam logic [LAT_W-1:0] LAT_MIN = 6'h01;
    // Preamble lengths in link clocks
    localparam logic [LAT_W-1:0] PRE_ONE = 6'h01;
    localparam logic [LAT_W-1:0] PRE_TWO = 6'h02;
    localparam logic [2:0]       UI_LAST = 3'h7;

    typedef struct packed {
        logic [LANES*BURST_UI-1:0] data;
        logic [LAT_W-1:0]          latency;
        logic                      pre_two;
        logic [1:0]                width;
    } burst_entry_t;

    localparam int ENTRY_W = $bits(burst_entry_t);

endpackage

// *** src/burst_fifo_if.sv ***
/*
 * Carrier between the formatter and its burst FIFO.
 * Fill side lives on ref_clk, drain side on the link clock.
 */
`timescale 1ns/10ps
interface burst_fifo_if #(
    parameter int WIDTH = 8
);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;

    modport fifo_fill  (input in_valid, input in_data, output in_ready);
    modport fifo_drain (output out_valid, output out_data, input out_ready);
    modport user_fill  (output in_valid, output in_data, input in_ready);
    modport user_drain (input out_valid, input out_data, output out_ready);
endinterface

// *** src/burst_fifo.sv ***
/*
 * Dual-clock FIFO with gray-coded pointers, width and depth as parameters.
 * Assumes each reset is synchronous to its own clock; DEPTH a power of two.
 */
`timescale 1ns/10ps
module burst_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Fill domain
    input  wire logic          wr_clk,
    input  wire logic          wr_rst,
    input  wire logic          wr_ce,
    burst_fifo_if.fifo_fill    fill,
    // Drain domain
    input  wire logic          rd_clk,
    input  wire logic          rd_rst,
    input  wire logic          rd_ce,
    burst_fifo_if.fifo_drain   drain
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wbin_ff;
    logic [AW:0]      wgray_ff;
    logic [AW:0]      rbin_ff;
    logic [AW:0]      rgray_ff;
    logic [AW:0]      rgray_s1_ff;
    logic [AW:0]      rgray_s2_ff;
    logic [AW:0]      wgray_s1_ff;
    logic [AW:0]      wgray_s2_ff;
    logic             ready_ff;
    logic             valid_ff;
    logic [AW:0]      nxt_wbin;
    logic [AW:0]      nxt_wgray;
    logic [AW:0]      nxt_rbin;
    logic [AW:0]      nxt_rgray;
    logic             push;
    logic             pop;

    assign push      = fill.in_valid && ready_ff;
    assign pop       = drain.out_ready && valid_ff;
    assign nxt_wbin  = wbin_ff + (AW+1)'(push);
    assign nxt_wgray = nxt_wbin ^ (nxt_wbin >> 1);
    assign nxt_rbin  = rbin_ff + (AW+1)'(pop);
    assign nxt_rgray = nxt_rbin ^ (nxt_rbin >> 1);

    assign fill.in_ready   = ready_ff;
    assign drain.out_valid = valid_ff;
    assign drain.out_data  = mem[rbin_ff[AW-1:0]];

    always_ff @(posedge wr_clk) begin
        if (wr_ce && push) begin
            mem[wbin_ff[AW-1:0]] <= fill.in_data;
        end
    end

    // Full is registered so the fill side sees ready straight from a flop
    always_ff @(posedge wr_clk) begin
        if (wr_rst) begin
            wbin_ff  <= '0;
            wgray_ff <= '0;
            ready_ff <= 1'b0;
        end else if (wr_ce) begin
            wbin_ff  <= nxt_wbin;
            wgray_ff <= nxt_wgray;
            ready_ff <= nxt_wgray !=
                        {~rgray_s2_ff[AW:AW-1], rgray_s2_ff[AW-2:0]};
        end
    end

    always_ff @(posedge wr_clk) begin
        if (wr_rst) begin
            rgray_s1_ff <= '0;
            rgray_s2_ff <= '0;
        end else if (wr_ce) begin
            rgray_s1_ff <= rgray_ff;
            rgray_s2_ff <= rgray_s1_ff;
        end
    end

    always_ff @(posedge rd_clk) begin
        if (rd_rst) begin
            rbin_ff  <= '0;
            rgray_ff <= '0;
            valid_ff <= 1'b0;
        end else if (rd_ce) begin
            rbin_ff  <= nxt_rbin;
            rgray_ff <= nxt_rgray;
            valid_ff <= nxt_rgray != wgray_s2_ff;
        end
    end

    always_ff @(posedge rd_clk) begin
        if (rd_rst) begin
            wgray_s1_ff <= '0;
            wgray_s2_ff <= '0;
        end else if (rd_ce) begin
            wgray_s1_ff <= wgray_ff;
            wgray_s2_ff <= wgray_s1_ff;
        end
    end
endmodule

// *** src/pattern_register_readout_formatter.sv ***
/*
 * Pattern-register readout formatter: turns four 8-bit pattern registers
 * into 8-UI read bursts on up to 16 data lanes with strobes.
 * Assumes commands and settings come from logic on ref_clk; the data
 * lanes and strobes are clocked by link_clk, one UI per link clock.
 */

`timescale 1ns/10ps
module pattern_register_readout_formatter (
    // Command clock domain
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        ce,

    // Read commands
    input  wire logic        read_command,
    input  wire logic [1:0]  cmd_bank,
    output logic             cmd_ready,

    // Settings
    input  wire logic [1:0]  mode_register_three_layout,
    input  wire logic [1:0]  width_code,
    input  wire logic [4:0]  additive_latency,
    input  wire logic [4:0]  cas_latency,
    input  wire logic        preamble_two_ck,
    input  wire logic [31:0] pattern_scratch_register,

    // Link clock domain
    input  wire logic        link_clk,
    output logic [15:0]      dq_out,
    output logic [15:0]      dq_oe,
    output logic             dqs_out,
    output logic             dqs_oe
);
    localparam int LANES = pattern_readout_pkg::LANES;
    localparam int UIS   = pattern_readout_pkg::BURST_UI;
    localparam int PBITS = pattern_readout_pkg::PAT_BITS;
    localparam int LAT_W = pattern_readout_pkg::LAT_W;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_WAIT,
        LINK_BURST
    } link_state_t;

    // Command side
    logic [PBITS-1:0]          loc_pat [pattern_readout_pkg::PAT_LOCS];

    logic [1:0]                layout_eff;
    logic [LANES*UIS-1:0]      fmt_bits;

    logic [LAT_W-1:0]          read_lat;
    pattern_readout_pkg::burst_entry_t wr_entry;

    // Link side
    logic                      rst_s1_ff;
    logic                      rst_s2_ff;

    logic                      ce_s1_ff;
    logic                      ce_s2_ff;

    link_state_t               state_ff;
    logic [LAT_W-1:0]          cnt_ff;
    logic [2:0]                ui_ff;

    pattern_readout_pkg::burst_entry_t cur_ff;
    pattern_readout_pkg::burst_entry_t rd_entry;
    logic                      take;

    logic [LAT_W-1:0]          pre_len;
    logic [15:0]               lane_mask;

    logic [15:0]               dq_out_ff;
    logic [15:0]               dq_oe_ff;

    logic                      dqs_out_ff;
    logic                      dqs_oe_ff;

    burst_fifo_if #(.WIDTH(pattern_readout_pkg::ENTRY_W)) fifo_bus ();

    generate
        for (genvar k = 0; k < pattern_readout_pkg::PAT_LOCS; k++)
        begin : g_loc
            assign loc_pat[k] = pattern_scratch_register[k*PBITS +: PBITS];
        end
    endgenerate

    always_comb begin
        if (mode_register_three_layout ==
            pattern_readout_pkg::LAYOUT_RESERVED) begin
            layout_eff = pattern_readout_pkg::LAYOUT_SERIAL;
        end else begin
            layout_eff = mode_register_three_layout;
        end
    end

    // One bit per lane and UI; word UI u occupies bits [u*16 +: 16]
    generate
        for (genvar u = 0; u < UIS; u++) begin : g_ui
            for (genvar l = 0; l < LANES; l++) begin : g_lane
                localparam logic [1:0] LOFS = 2'(l % 4);
                localparam int PPOS = PBITS - 1 - (l % PBITS);
                localparam int UPOS = PBITS - 1 - u;

                always_comb begin
                    unique case (layout_eff)
                        pattern_readout_pkg::LAYOUT_PARALLEL: begin
                            fmt_bits[u*LANES+l] = loc_pat[0][PPOS];
                        end
                        pattern_readout_pkg::LAYOUT_STAGGERED: begin
                            fmt_bits[u*LANES+l] =
                                loc_pat[cmd_bank + LOFS][UPOS];
                        end
                        default: begin
                            fmt_bits[u*LANES+l] = loc_pat[cmd_bank][UPOS];
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Read latency is additive plus CAS
    assign read_lat = LAT_W'(additive_latency) + LAT_W'(cas_latency);

    always_comb begin
        wr_entry.data    = fmt_bits;
        wr_entry.latency = read_lat;
        wr_entry.pre_two = preamble_two_ck;
        wr_entry.width   = width_code;
    end

    // Commands offered while the FIFO is full are lost; cmd_ready warns
    assign fifo_bus.in_valid = read_command && ce;
    assign fifo_bus.in_data  = wr_entry;
    assign cmd_ready         = fifo_bus.in_ready;

    burst_fifo #(
        .WIDTH(pattern_readout_pkg::ENTRY_W),
        .DEPTH(pattern_readout_pkg::FIFO_DEPTH)
    ) u_fifo (
        .wr_clk (ref_clk),
        .wr_rst (srst),
        .wr_ce  (ce),
        .fill   (fifo_bus),
        .rd_clk (link_clk),
        .rd_rst (rst_s2_ff),
        .rd_ce  (ce_s2_ff),
        .drain  (fifo_bus)
    );

    // Reset and enable brought into the link domain
    always_ff @(posedge link_clk) begin
        rst_s1_ff <= srst;
        rst_s2_ff <= rst_s1_ff;
    end

    always_ff @(posedge link_clk) begin
        ce_s1_ff <= ce;
        ce_s2_ff <= ce_s1_ff;
    end

    assign rd_entry = fifo_bus.out_data;
    always_comb begin
        take = 1'b0;
        if (ce_s2_ff && fifo_bus.out_valid) begin
            if (state_ff == LINK_IDLE) begin
                take = 1'b1;
            end else if (state_ff == LINK_BURST &&
                         ui_ff == pattern_readout_pkg::UI_LAST) begin
                take = 1'b1;
            end
        end
    end
    assign fifo_bus.out_ready = take;

    always_ff @(posedge link_clk) begin
        if (rst_s2_ff) begin
            state_ff <= LINK_IDLE;
        end else if (ce_s2_ff) begin
            unique case (state_ff)
                LINK_IDLE: begin
                    if (take) begin
                        state_ff <= LINK_WAIT;
                    end
                end
                LINK_WAIT: begin
                    if (cnt_ff == pattern_readout_pkg::LAT_MIN) begin
                        state_ff <= LINK_BURST;
                    end
                end
                LINK_BURST: begin
                    // Chain the next burst with no gap
                    if (ui_ff == pattern_readout_pkg::UI_LAST && !take) begin
                        state_ff <= LINK_IDLE;
                    end
                end
            endcase
        end
    end

    // Latency of zero still waits one link clock
    always_ff @(posedge link_clk) begin
        if (rst_s2_ff) begin
            cnt_ff <= '0;
        end else if (ce_s2_ff) begin
            if (state_ff == LINK_IDLE && take) begin
                if (rd_entry.latency < pattern_readout_pkg::LAT_MIN) begin
                    cnt_ff <= pattern_readout_pkg::LAT_MIN;
                end else begin
                    cnt_ff <= rd_entry.latency;
                end
            end else if (state_ff == LINK_WAIT) begin
                cnt_ff <= cnt_ff - LAT_W'(1);
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (rst_s2_ff) begin
            ui_ff <= '0;
        end else if (ce_s2_ff) begin
            if (state_ff == LINK_BURST) begin
                ui_ff <= ui_ff + 3'h1;
            end else begin
                ui_ff <= '0;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (rst_s2_ff) begin
            cur_ff <= '0;
        end else if (ce_s2_ff && take) begin
            cur_ff <= rd_entry;
        end
    end

    always_comb begin
        if (cur_ff.pre_two) begin
            pre_len = pattern_readout_pkg::PRE_TWO;
        end else begin
            pre_len = pattern_readout_pkg::PRE_ONE;
        end
    end

    always_comb begin
        unique case (cur_ff.width)
            pattern_readout_pkg::WIDTH_X4: begin
                lane_mask = pattern_readout_pkg::LANE_MASK_X4;
            end
            pattern_readout_pkg::WIDTH_X8: begin
                lane_mask = pattern_readout_pkg::LANE_MASK_X8;
            end
            default: begin
                lane_mask = pattern_readout_pkg::LANE_MASK_X16;
            end
        endcase
    end

    // Pins follow the state by one link clock, straight from flops
    always_ff @(posedge link_clk) begin
        if (rst_s2_ff) begin
            dq_out_ff <= '0;
        end else if (ce_s2_ff) begin
            if (state_ff == LINK_BURST) begin
                dq_out_ff <= cur_ff.data[ui_ff*LANES +: LANES] & lane_mask;
            end else begin
                dq_out_ff <= '0;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (rst_s2_ff) begin
            dq_oe_ff <= '0;
        end else if (ce_s2_ff) begin
            if (state_ff == LINK_BURST) begin
                dq_oe_ff <= lane_mask;
            end else begin
                dq_oe_ff <= '0;
            end
        end
    end

    // Strobe with preamble, then one edge per UI
    always_ff @(posedge link_clk) begin
        if (rst_s2_ff) begin
            dqs_out_ff <= 1'b0;
        end else if (ce_s2_ff) begin
            if (state_ff == LINK_BURST) begin
                dqs_out_ff <= ~ui_ff[0];
            end else begin
                dqs_out_ff <= 1'b0;
            end
        end
    end

    // Preamble is a static low while the latency runs out
    always_ff @(posedge link_clk) begin
        if (rst_s2_ff) begin
            dqs_oe_ff <= 1'b0;
        end else if (ce_s2_ff) begin
            if (state_ff == LINK_BURST ||
                (state_ff == LINK_WAIT && cnt_ff <= pre_len)) begin
                dqs_oe_ff <= 1'b1;
            end else begin
                dqs_oe_ff <= 1'b0;
            end
        end
    end

    assign dq_out  = dq_out_ff;
    assign dq_oe   = dq_oe_ff;
    assign dqs_out = dqs_out_ff;
    assign dqs_oe  = dqs_oe_ff;
endmodule

// *** testbench/pattern_readout_monitor.sv ***
/*
 * Checker on the formatter's top-level ports, bound below.
 * Assumes both clocks run freely and srst is held at start of run.
 */
`timescale 1ns/10ps
module pattern_readout_monitor (
    // Command domain
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        ce,
    input wire logic        read_command,
    input wire logic [1:0]  cmd_bank,
    input wire logic        cmd_ready,
    // Settings
    input wire logic [1:0]  mode_register_three_layout,
    input wire logic [1:0]  width_code,
    input wire logic [4:0]  additive_latency,
    input wire logic [4:0]  cas_latency,
    input wire logic        preamble_two_ck,
    input wire logic [31:0] pattern_scratch_register,
    // Link domain
    input wire logic        link_clk,
    input wire logic [15:0] dq_out,
    input wire logic [15:0] dq_oe,
    input wire logic        dqs_out,
    input wire logic        dqs_oe
);
    logic       drv;
    logic [2:0] ui_ff;

    assign drv = |dq_oe;

    // UIs driven so far, modulo one burst
    always_ff @(posedge link_clk) begin
        if (srst) begin
            ui_ff <= 3'h0;
        end else begin
            ui_ff <= drv ? ui_ff + 3'h1 : 3'h0;
        end
    end

    sequence pre_one;
        !dqs_out && !drv ##1 drv && dqs_out;
    endsequence
    sequence pre_two;
        (!dqs_out && !drv) [*2] ##1 drv && dqs_out;
    endsequence

    a_lane_mask_legal: assert property (@(posedge link_clk)
        disable iff (srst) drv |-> dq_oe inside {16'h000f, 16'h00ff, 16'hffff})
        else $error("lane enable is not a width mask");
    a_masked_lanes_low: assert property (@(posedge link_clk)
        disable iff (srst) (dq_out & ~dq_oe) == 16'h0000)
        else $error("disabled lane carries data");
    a_data_strobed: assert property (@(posedge link_clk)
        disable iff (srst) drv |-> dqs_oe)
        else $error("data driven without strobe");
    a_strobe_toggles: assert property (@(posedge link_clk)
        disable iff (srst) drv && $past(drv) |-> dqs_out != $past(dqs_out))
        else $error("strobe did not toggle during data");
    a_preamble_one: assert property (@(posedge link_clk)
        disable iff (srst) $rose(dqs_oe) && !preamble_two_ck |-> pre_one)
        else $error("one-clock preamble wrong");
    a_preamble_two: assert property (@(posedge link_clk)
        disable iff (srst) $rose(dqs_oe) && preamble_two_ck |-> pre_two)
        else $error("two-clock preamble wrong");
    a_burst_whole: assert property (@(posedge link_clk)
        disable iff (srst) !drv |-> ui_ff == 3'h0)
        else $error("burst not a whole number of 8 UIs");
    a_upper_byte_copy: assert property (@(posedge link_clk)
        disable iff (srst) dq_oe == 16'hffff |-> dq_out[15:8] == dq_out[7:0])
        else $error("upper byte differs from lower byte");
    a_idle_quiet: assert property (@(posedge link_clk)
        disable iff (srst) !dqs_oe |-> !dqs_out && !drv)
        else $error("activity with strobe disabled");
endmodule

bind pattern_register_readout_formatter pattern_readout_monitor
    pattern_readout_monitor_i (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .read_command(read_command),
    .cmd_bank(cmd_bank), .cmd_ready(cmd_ready),
    .mode_register_three_layout(mode_register_three_layout),
    .width_code(width_code), .additive_latency(additive_latency),
    .cas_latency(cas_latency), .preamble_two_ck(preamble_two_ck),
    .pattern_scratch_register(pattern_scratch_register),
    .link_clk(link_clk), .dq_out(dq_out), .dq_oe(dq_oe),
    .dqs_out(dqs_out), .dqs_oe(dqs_oe));

// *** testbench/link_capture.sv ***
/*
 * Controller-side read receiver: gathers 8-UI bursts from the lanes.
 * Assumes one UI per rising link_clk edge; passive, drives nothing.
 */
`timescale 1ns/10ps
module link_capture (
    // Lanes seen by the controller
    input wire logic        link_clk,
    input wire logic [15:0] dq_out,
    input wire logic [15:0] dq_oe
);
    logic [127:0] acc;
    logic [143:0] burst_q[$];
    int           ui;
    int           chained;
    bit           at_end;

    initial begin
        acc = '0;
        ui = 0;
        chained = 0;
        at_end = 1'b0;
    end

    // A burst starting right after the last UI of another is chained
    always @(posedge link_clk) begin
        if (dq_oe !== 16'h0000) begin
            if (ui == 0 && at_end) chained++;
            acc[16*ui +: 16] = dq_out;
            at_end = (ui == 7);
            if (at_end) burst_q.push_back({dq_oe, acc});
            ui = at_end ? 0 : ui + 1;
        end else begin
            at_end = 1'b0;
            ui = 0;
        end
    end
endmodule

// *** testbench/tb_pattern_register_readout_formatter.sv ***
/*
 * Bench: corner and random pattern reads, bursts compared with a model.
 * Assumes the design, checker and capture model are compiled first.
 */
`timescale 1ns/10ps
module tb_pattern_register_readout_formatter;
    logic         ref_clk;
    logic         link_clk;
    logic         srst;
    logic         ce;
    logic         read_command;
    logic         cmd_ready;
    logic         pre_two;
    logic [1:0]   cmd_bank;
    logic [1:0]   layout;
    logic [1:0]   width_code;
    logic [4:0]   add_lat;
    logic [4:0]   cas_lat;
    logic [31:0]  pattern;
    logic [15:0]  dq_out;
    logic [15:0]  dq_oe;
    logic         dqs_out;
    logic         dqs_oe;
    logic [143:0] exp_q[$];
    int           num_errors;
    int           n_compared;
    int           seed;

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.7;
        forever #3 link_clk = ~link_clk;
    end

    pattern_register_readout_formatter pattern_register_readout_formatter_i (
        .ref_clk(ref_clk), .srst(srst), .ce(ce),
        .read_command(read_command), .cmd_bank(cmd_bank),
        .cmd_ready(cmd_ready), .mode_register_three_layout(layout),
        .width_code(width_code), .additive_latency(add_lat),
        .cas_latency(cas_lat), .preamble_two_ck(pre_two),
        .pattern_scratch_register(pattern), .link_clk(link_clk),
        .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe));
    link_capture link_capture_i (
        .link_clk(link_clk), .dq_out(dq_out), .dq_oe(dq_oe));

    function automatic logic [15:0] lane_mask(logic [1:0] w);
        case (w)
            2'h0: return pattern_readout_pkg::LANE_MASK_X4;
            2'h1: return pattern_readout_pkg::LANE_MASK_X8;
            default: return pattern_readout_pkg::LANE_MASK_X16;
        endcase
    endfunction

    // Lane l at UI u sits at bit 16*u+l; pattern bit 7 goes out first
    function automatic logic [127:0] exp_data(logic [1:0] lay, int b,
                                              logic [31:0] p, logic [15:0] m);
        logic [127:0] d;
        logic [7:0]   v;
        d = '0;
        for (int u = 0; u < 8; u++) begin
            for (int l = 0; l < 16; l++) begin
                if (lay == pattern_readout_pkg::LAYOUT_PARALLEL) begin
                    v = p[7:0];
                    d[16*u+l] = v[7-l%8] & m[l];
                end else begin
                    v = p[8*b +: 8];
                    if (lay == pattern_readout_pkg::LAYOUT_STAGGERED)
                        v = p[8*((b+l%4)%4) +: 8];
                    d[16*u+l] = v[7-u] & m[l];
                end
            end
        end
        return d;
    endfunction

    task automatic check_burst(logic [143:0] got, logic [143:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_range(int got, int lo, int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic issue(logic [1:0] lay, logic [1:0] w, logic [1:0] b,
                         logic [31:0] p);
        int n;
        n = 0;
        @(posedge ref_clk);
        while (cmd_ready !== 1'b1 && n < 100) begin
            n++;
            @(posedge ref_clk);
        end
        read_command <= 1'b1;
        cmd_bank <= b;
        layout <= lay;
        width_code <= w;
        pattern <= p;
        exp_q.push_back({lane_mask(w), exp_data(lay, b, p, lane_mask(w))});
    endtask

    task automatic idle();
        @(posedge ref_clk);
        read_command <= 1'b0;
    endtask

    task automatic drain(string name);
        int n;
        n = 0;
        while (link_capture_i.burst_q.size() < exp_q.size() && n < 3000) begin
            n++;
            @(posedge ref_clk);
        end
        check_range(link_capture_i.burst_q.size(), exp_q.size(), exp_q.size());
        while (exp_q.size() > 0 && link_capture_i.burst_q.size() > 0)
            check_burst(link_capture_i.burst_q.pop_front(), exp_q.pop_front());
        exp_q.delete();
        $display("test %s done", name);
    endtask

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #400000;
        num_errors++;
        final_report();
    end

    initial begin
        logic [31:0] p;
        logic [4:0]  al;
        logic [4:0]  cl;
        logic [1:0]  lay;
        int          n;
        int          c0;
        seed = 18;
        num_errors = 0;
        n_compared = 0;
        srst = 1'b1;
        ce = 1'b1;
        read_command = 1'b0;
        cmd_bank = 2'h0;
        layout = 2'h0;
        width_code = 2'h0;
        add_lat = 5'h00;
        cas_lat = 5'h04;
        pre_two = 1'b0;
        pattern = 32'h0000_0000;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check_range(cmd_ready, 1, 1);
        issue(2'h0, 2'h2, 2'h0, 32'h0000_007f);
        idle();
        issue(2'h1, 2'h0, 2'h0, 32'h0000_007f);
        idle();
        drain("corner");
        for (int i = 0; i < 24; i++) begin
            lay = 2'(i);
            pre_two <= 1'($random(seed));
            add_lat <= 5'($random(seed) & 3);
            cas_lat <= 5'h02 + 5'($random(seed) & 3);
            // parallel reads stay on location 0
            issue(lay, 2'(i / 4 % 3), lay == 2'h1 ? 2'h0 : 2'($random(seed)),
                  $random(seed));
            idle();
            drain("layout table");
        end
        p = $random(seed);
        c0 = link_capture_i.chained;
        for (int i = 0; i < 8; i++)
            issue(2'h2, 2'(i / 4), 2'(i), p);
        idle();
        drain("back to back");
        check_range(link_capture_i.chained - c0, 7, 7);
        al = 5'h08 + 5'($random(seed) & 7);
        cl = 5'h09 + 5'($random(seed) & 7);
        add_lat <= al;
        cas_lat <= cl;
        pre_two <= 1'b1;
        issue(2'h3, 2'h1, 2'h1, $random(seed));
        idle();
        n = 0;
        while (dq_oe === 16'h0000 && n < 300) begin
            @(posedge link_clk);
            n++;
        end
        check_range(n, al + cl + 1, al + cl + 14);
        drain("latency");
        final_report();
    end
endmodule
